// file: rtl/pafo_pkg.sv
/*
 * Shared constants and state type for the port alternate function override.
 * Assumes one 8-bit port A and one 8-bit port B sharing a single system clock.
 */
package pafo_pkg;

   localparam int PORT_W = 8;

   // Port B pin positions of each alternate function
   localparam int BIT_TMR_SHARED = 7;
   localparam int BIT_T1_CMP_B   = 6;
   localparam int BIT_T1_CMP_A   = 5;
   localparam int BIT_T0_CMP     = 4;
   localparam int BIT_SPI_MISO   = 3;
   localparam int BIT_SPI_MOSI   = 2;
   localparam int BIT_SPI_SCK    = 1;
   localparam int BIT_SPI_SEL    = 0;
   localparam int SPI_IN_W       = 4;

   // Reset values: drivers off, pull-ups off, outputs low
   localparam logic [PORT_W-1:0]   OE_B_RST = 8'hFF;
   localparam logic [PORT_W-1:0]   OUT_RST  = 8'h00;
   localparam logic [PORT_W-1:0]   PULL_RST = 8'h00;
   localparam logic [SPI_IN_W-1:0] SPI_RST  = 4'h0;

   // Input enable is never overridden by these functions
   localparam logic INPUT_EN_OVR_EN  = 1'b0;
   localparam logic INPUT_EN_OVR_VAL = 1'b0;

   typedef struct packed {
      logic [PORT_W-1:0]   pinAOut;
      logic [PORT_W-1:0]   pinAOeB;
      logic [PORT_W-1:0]   pinAPullup;
      logic [PORT_W-1:0]   pinBOut;
      logic [PORT_W-1:0]   pinBOeB;
      logic [PORT_W-1:0]   pinBPullup;
      logic [PORT_W-1:0]   altInA;
      logic [SPI_IN_W-1:0] altInB;
      logic [PORT_W-1:0]   syncA1;
      logic [PORT_W-1:0]   syncA2;
      logic [PORT_W-1:0]   syncB1;
      logic [PORT_W-1:0]   syncB2;
   } pafo_state_t;

endpackage

// file: rtl/pafo_ovr_if.sv
/*
 * Override bundle between the override source and the per-pin resolver.
 * Assumes the source drives overrides and general I/O bits in the same cycle.
 */
`timescale 1ns/100ps
interface pafo_ovr_if #(parameter int W = 8);
   logic [W-1:0] pullupOverrideEn;
   logic [W-1:0] pullupOverrideVal;
   logic [W-1:0] directionOverrideEn;
   logic [W-1:0] directionOverrideVal;
   logic [W-1:0] outValueOverrideEn;
   logic [W-1:0] outValueOverrideVal;
   logic [W-1:0] dirBits;
   logic [W-1:0] latchBits;
   logic         globalPullupDisable;
   logic [W-1:0] pullupOn;
   logic [W-1:0] driverOn;
   logic [W-1:0] driveVal;

   modport src (
      output pullupOverrideEn, pullupOverrideVal, directionOverrideEn,
             directionOverrideVal, outValueOverrideEn, outValueOverrideVal,
             dirBits, latchBits, globalPullupDisable,
      input  pullupOn, driverOn, driveVal
   );
   modport res (
      input  pullupOverrideEn, pullupOverrideVal, directionOverrideEn,
             directionOverrideVal, outValueOverrideEn, outValueOverrideVal,
             dirBits, latchBits, globalPullupDisable,
      output pullupOn, driverOn, driveVal
   );
endinterface

// file: rtl/pafo_pin_resolve.sv
/*
 * Per-pin resolution of pull-up, driver enable and driven value from overrides.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/100ps
module pafo_pin_resolve #(
   parameter int W = 8
) (
   pafo_ovr_if.res ovr
);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : gBit
         // Normal pull-up only for an input pin with its latch set
         assign ovr.pullupOn[i] = ovr.pullupOverrideEn[i] ? ovr.pullupOverrideVal[i]
            : (~ovr.dirBits[i] & ovr.latchBits[i] & ~ovr.globalPullupDisable);
         assign ovr.driverOn[i] = ovr.directionOverrideEn[i] ? ovr.directionOverrideVal[i]
            : ovr.dirBits[i];
         assign ovr.driveVal[i] = ovr.outValueOverrideEn[i] ? ovr.outValueOverrideVal[i]
            : ovr.latchBits[i];
      end
   endgenerate

endmodule

// file: rtl/pafo_port_alt_function_override.sv
/*
 * Port A / port B alternate function override with registered pad controls.
 * Assumes memory interface, timers and SPI share clk_sys; pads arrive unsynced.
 */
// Overview of operation
// - Port A pins become the external memory low address/data bus when enabled.
// - Port A pin n carries bus bit n, pin 7 most significant.
// - Port A pull-up, direction and value override enables equal memory enable.
// - Port A driver on during write or address phase, otherwise off.
// - Drive address bit in address phase, write data bit in write phase.
// - Port A pull-up value: no bus phase AND latch bit AND global term.
// - Input enable overrides are zero; pin input returned as memory read data.
// - Port B bit 7 carries timer 2 PWM waveform.
// - Port B bit 7 may carry timer 1 output C when direction is output.
// - Timer 1 output C unavailable in legacy compatibility mode.
// - Port B bits 6,5,4 carry timer 1 B, timer 1 A, timer 0 outputs.
// - Port B bits 3,2,1 carry SPI MISO, MOSI and SCK.
// - Port B bit 0 carries SPI slave select input.
// - Pull-up follows override value when enabled, else normal settings.
// - Driver follows direction override when enabled, else direction bit.
// - Driven value follows value override when enabled, else latch bit.
// - Alternate function input taken before the port synchronizer.
`timescale 1ns/100ps
module pafo_port_alt_function_override
   import pafo_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                rst_b,
   input  wire logic                extMemEnable,
   input  wire logic                addressPhaseActive,
   input  wire logic                writePhase,
   input  wire logic [PORT_W-1:0]   extAddrLow,
   input  wire logic [PORT_W-1:0]   extDataOut,
   input  wire logic                globalPullupDisable,
   input  wire logic [PORT_W-1:0]   portAOutLatch,
   input  wire logic [PORT_W-1:0]   portADirection,
   input  wire logic [PORT_W-1:0]   portAPinIn,
   input  wire logic [PORT_W-1:0]   portBOutLatch,
   input  wire logic [PORT_W-1:0]   portBDirection,
   input  wire logic [PORT_W-1:0]   portBPinIn,
   input  wire logic                legacyCompatMode,
   input  wire logic                timer2CompareEn,
   input  wire logic                timer2CompareOut,
   input  wire logic                timer1CompareEnC,
   input  wire logic                timer1CompareOutC,
   input  wire logic                timer1CompareEnB,
   input  wire logic                timer1CompareOutB,
   input  wire logic                timer1CompareEnA,
   input  wire logic                timer1CompareOutA,
   input  wire logic                timer0CompareEn,
   input  wire logic                timer0CompareOut,
   input  wire logic                spiEnable,
   input  wire logic                spiMaster,
   input  wire logic                spiSlaveOut,
   input  wire logic                spiMasterOut,
   input  wire logic                spiSckOut,
   output logic      [PORT_W-1:0]   portAPinOut,
   output logic      [PORT_W-1:0]   portAPinOe_b,
   output logic      [PORT_W-1:0]   portAPullup,
   output logic      [PORT_W-1:0]   portBPinOut,
   output logic      [PORT_W-1:0]   portBPinOe_b,
   output logic      [PORT_W-1:0]   portBPullup,
   output logic      [PORT_W-1:0]   altFunctionInput,
   output logic                     spiMisoIn,
   output logic                     spiMosiIn,
   output logic                     spiSckIn,
   output logic                     spiSlaveSelectIn,
   output logic      [PORT_W-1:0]   portAPinRead,
   output logic      [PORT_W-1:0]   portBPinRead
);

   pafo_state_t         st_r;
   pafo_state_t         st_nxt;
   logic                busDrive;
   logic                spiMasterMode;
   logic                spiSlaveMode;
   logic [SPI_IN_W-1:0] spiForcedIn;
   logic                sharedEn;
   logic                sharedVal;
   logic                timer1CLive;

   pafo_ovr_if #(.W(PORT_W)) ovrA ();
   pafo_ovr_if #(.W(PORT_W)) ovrB ();

   pafo_pin_resolve #(.W(PORT_W)) uResolveA (
      .ovr (ovrA)
   );
   pafo_pin_resolve #(.W(PORT_W)) uResolveB (
      .ovr (ovrB)
   );

   // Port A: memory bus owns all eight pins while enabled
   assign busDrive = writePhase | addressPhaseActive;
   assign ovrA.pullupOverrideEn    = {PORT_W{extMemEnable}};
   assign ovrA.directionOverrideEn = {PORT_W{extMemEnable}};
   assign ovrA.outValueOverrideEn  = {PORT_W{extMemEnable}};
   assign ovrA.pullupOverrideVal   = {PORT_W{~busDrive}} & portAOutLatch
                                     & {PORT_W{globalPullupDisable}};
   assign ovrA.directionOverrideVal = {PORT_W{busDrive}};
   // Bit n of both buses lands on pin n
   assign ovrA.outValueOverrideVal = (extAddrLow & {PORT_W{addressPhaseActive}})
                                     | (extDataOut & {PORT_W{writePhase}});
   assign ovrA.dirBits             = portADirection;
   assign ovrA.latchBits           = portAOutLatch;
   assign ovrA.globalPullupDisable = globalPullupDisable;

   // Port B: shared bit 7 through the combining modulator
   assign timer1CLive = timer1CompareEnC & ~legacyCompatMode;
   assign sharedEn    = timer2CompareEn | timer1CLive;
   always_comb begin
      if (timer2CompareEn && timer1CLive) begin
         // Latch bit picks OR or AND so either timer can gate the other
         sharedVal = portBOutLatch[BIT_TMR_SHARED] ? (timer2CompareOut | timer1CompareOutC)
                                                   : (timer2CompareOut & timer1CompareOutC);
      end else if (timer2CompareEn) begin
         sharedVal = timer2CompareOut;
      end else begin
         sharedVal = timer1CompareOutC;
      end
   end

   assign spiMasterMode = spiEnable & spiMaster;
   assign spiSlaveMode  = spiEnable & ~spiMaster;
   // Pins the SPI forces to input; their pull-up stays with the latch
   assign spiForcedIn = {spiMasterMode, spiSlaveMode, spiSlaveMode, spiSlaveMode};
   assign ovrB.pullupOverrideEn    = {4'h0, spiForcedIn};
   assign ovrB.pullupOverrideVal   = {4'h0, portBOutLatch[SPI_IN_W-1:0]
                                     & ~{SPI_IN_W{globalPullupDisable}}};
   assign ovrB.directionOverrideEn = {4'h0, spiForcedIn};
   assign ovrB.directionOverrideVal = 8'h00;
   // Direction of timer pins stays with software, so no direction override
   assign ovrB.outValueOverrideEn  = {sharedEn, timer1CompareEnB, timer1CompareEnA,
                                      timer0CompareEn, spiSlaveMode, spiMasterMode,
                                      spiMasterMode, 1'b0};
   assign ovrB.outValueOverrideVal = {sharedVal, timer1CompareOutB, timer1CompareOutA,
                                      timer0CompareOut, spiSlaveOut, spiMasterOut,
                                      spiSckOut, 1'b0};
   assign ovrB.dirBits             = portBDirection;
   assign ovrB.latchBits           = portBOutLatch;
   assign ovrB.globalPullupDisable = globalPullupDisable;

   always_comb begin
      st_nxt            = st_r;
      st_nxt.pinAOut    = ovrA.driveVal;
      st_nxt.pinAOeB    = ~ovrA.driverOn;
      st_nxt.pinAPullup = ovrA.pullupOn;
      st_nxt.pinBOut    = ovrB.driveVal;
      st_nxt.pinBOeB    = ~ovrB.driverOn;
      st_nxt.pinBPullup = ovrB.pullupOn;
      // One capture flop only; receivers resynchronise themselves
      st_nxt.altInA     = portAPinIn;
      st_nxt.altInB     = portBPinIn[SPI_IN_W-1:0];
      st_nxt.syncA1     = portAPinIn;
      st_nxt.syncA2     = st_r.syncA1;
      st_nxt.syncB1     = portBPinIn;
      st_nxt.syncB2     = st_r.syncB1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st_r <= '{pinAOut: OUT_RST, pinAOeB: OE_B_RST, pinAPullup: PULL_RST,
                   pinBOut: OUT_RST, pinBOeB: OE_B_RST, pinBPullup: PULL_RST,
                   altInA: OUT_RST, altInB: SPI_RST, syncA1: OUT_RST,
                   syncA2: OUT_RST, syncB1: OUT_RST, syncB2: OUT_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign portAPinOut      = st_r.pinAOut;
   assign portAPinOe_b     = st_r.pinAOeB;
   assign portAPullup      = st_r.pinAPullup;
   assign portBPinOut      = st_r.pinBOut;
   assign portBPinOe_b     = st_r.pinBOeB;
   assign portBPullup      = st_r.pinBPullup;
   assign altFunctionInput = st_r.altInA;
   assign spiMisoIn        = st_r.altInB[BIT_SPI_MISO];
   assign spiMosiIn        = st_r.altInB[BIT_SPI_MOSI];
   assign spiSckIn         = st_r.altInB[BIT_SPI_SCK];
   assign spiSlaveSelectIn = st_r.altInB[BIT_SPI_SEL];
   assign portAPinRead     = st_r.syncA2;
   assign portBPinRead     = st_r.syncB2;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence sAddrPhase;
      extMemEnable && addressPhaseActive && !writePhase;
   endsequence
   sequence sWritePhase;
      extMemEnable && writePhase && !addressPhaseActive;
   endsequence

   a_bus_drive_on: assert property (
      extMemEnable && busDrive |=> portAPinOe_b == 8'h00)
      else $error("port A driver off during bus phase");
   a_bus_release: assert property (
      extMemEnable && !busDrive |=> portAPinOe_b == 8'hFF)
      else $error("port A driver on outside bus phase");
   a_addr_then_data: assert property (
      sAddrPhase ##1 sWritePhase |=> portAPinOut == $past(extDataOut)
         && $past(portAPinOut) == $past(extAddrLow, 2))
      else $error("port A address or data value wrong");
   a_bus_pullup: assert property (
      extMemEnable |=> portAPullup == $past(~{PORT_W{busDrive}} & portAOutLatch
                                            & {PORT_W{globalPullupDisable}}))
      else $error("port A pull-up override wrong");
   a_gpio_fallback: assert property (
      !extMemEnable |=> portAPinOe_b == $past(~portADirection)
         && portAPinOut == $past(portAOutLatch))
      else $error("port A not plain I/O with memory disabled");
   a_alt_input: assert property (
      $past(rst_b) |-> altFunctionInput == $past(portAPinIn)
         && (portAPinRead == $past(portAPinIn, 2) || !$past(rst_b, 2)))
      else $error("alternate input or synchroniser depth wrong");
   a_legacy_c_off: assert property (
      legacyCompatMode && !timer2CompareEn |=> portBPinOut[BIT_TMR_SHARED]
         == $past(portBOutLatch[BIT_TMR_SHARED]))
      else $error("timer 1 output C active in legacy mode");
   a_timer_a_pin: assert property (
      timer1CompareEnA && portBDirection[BIT_T1_CMP_A] |=>
         !portBPinOe_b[BIT_T1_CMP_A] && portBPinOut[BIT_T1_CMP_A] == $past(timer1CompareOutA))
      else $error("timer 1 output A not on port B bit 5");
   a_spi_master_in: assert property (
      spiMasterMode |=> portBPinOe_b[BIT_SPI_MISO]
         && portBPinOut[BIT_SPI_SCK] == $past(spiSckOut))
      else $error("SPI master pin setup wrong");

endmodule

// file: test/pafo_pad_model.sv
/*
 * Pad model for ports A and B: external drivers, pull-ups and floating pins.
 * Assumes active-low output enables from the design and one shared clock.
 */
`timescale 1ns/100ps
module pafo_pad_model
   import pafo_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic [PORT_W-1:0] pinAOut,
   input  wire logic [PORT_W-1:0] pinAOe_b,
   input  wire logic [PORT_W-1:0] pinAPullup,
   input  wire logic [PORT_W-1:0] pinBOut,
   input  wire logic [PORT_W-1:0] pinBOe_b,
   input  wire logic [PORT_W-1:0] pinBPullup,
   input  wire logic [PORT_W-1:0] extA,
   input  wire logic [PORT_W-1:0] extAEn,
   input  wire logic [PORT_W-1:0] extB,
   input  wire logic [PORT_W-1:0] extBEn,
   output logic      [PORT_W-1:0] pinAIn,
   output logic      [PORT_W-1:0] pinBIn
);
   logic [PORT_W-1:0] floatPat_r = 8'hA5;

   // Undriven pins with no pull-up toggle so a stale value can never pass as read data
   always @(posedge clk_sys) begin
      floatPat_r <= ~floatPat_r;
   end

   function automatic logic [PORT_W-1:0] padLevel(input logic [PORT_W-1:0] o, oeB, pu,
                                                  ext, extEn, flt);
      return (~oeB & o) | (oeB & extEn & ext) | (oeB & ~extEn & pu) |
             (oeB & ~extEn & ~pu & flt);
   endfunction

   assign pinAIn = padLevel(pinAOut, pinAOe_b, pinAPullup, extA, extAEn, floatPat_r);
   assign pinBIn = padLevel(pinBOut, pinBOe_b, pinBPullup, extB, extBEn, floatPat_r);
endmodule

// file: test/pafo_port_alt_function_override_tb_top.sv
/*
 * Self-checking bench for the port alternate function override.
 * Assumes one-cycle registered pad outputs and a pad model on the far side.
 */
`timescale 1ns/100ps
module pafo_port_alt_function_override_tb_top
   import pafo_pkg::*;
;
   logic clk_sys, rst_b, extMemEnable, addressPhaseActive, writePhase, globalPullupDisable;
   logic legacyCompatMode, spiEnable, spiMaster, spiSlaveOut, spiMasterOut, spiSckOut;
   logic timer2CompareEn, timer2CompareOut, timer1CompareEnC, timer1CompareOutC;
   logic timer1CompareEnB, timer1CompareOutB, timer1CompareEnA, timer1CompareOutA;
   logic timer0CompareEn, timer0CompareOut, spiMisoIn, spiMosiIn, spiSckIn, spiSlaveSelectIn;
   logic [PORT_W-1:0] extAddrLow, extDataOut, portAOutLatch, portADirection, portAPinIn;
   logic [PORT_W-1:0] portBOutLatch, portBDirection, portBPinIn, extA, extAEn, extB, extBEn;
   logic [PORT_W-1:0] portAPinOut, portAPinOe_b, portAPullup, portBPinOut, portBPinOe_b;
   logic [PORT_W-1:0] portBPullup, altFunctionInput, portAPinRead, portBPinRead;
   logic [6:0]        bit7Tbl [7];
   int                num_errors = 0;
   int                total_checks = 0;

   pafo_port_alt_function_override pafo_port_alt_function_override_inst (
      .clk_sys, .rst_b, .extMemEnable, .addressPhaseActive, .writePhase, .extAddrLow,
      .extDataOut, .globalPullupDisable, .portAOutLatch, .portADirection, .portAPinIn,
      .portBOutLatch, .portBDirection, .portBPinIn, .legacyCompatMode, .timer2CompareEn,
      .timer2CompareOut, .timer1CompareEnC, .timer1CompareOutC, .timer1CompareEnB,
      .timer1CompareOutB, .timer1CompareEnA, .timer1CompareOutA, .timer0CompareEn,
      .timer0CompareOut, .spiEnable, .spiMaster, .spiSlaveOut, .spiMasterOut, .spiSckOut,
      .portAPinOut, .portAPinOe_b, .portAPullup, .portBPinOut, .portBPinOe_b, .portBPullup,
      .altFunctionInput, .spiMisoIn, .spiMosiIn, .spiSckIn, .spiSlaveSelectIn,
      .portAPinRead, .portBPinRead);

   pafo_pad_model pafo_pad_model_inst (
      .clk_sys, .pinAOut(portAPinOut), .pinAOe_b(portAPinOe_b), .pinAPullup(portAPullup),
      .pinBOut(portBPinOut), .pinBOe_b(portBPinOe_b), .pinBPullup(portBPullup),
      .extA, .extAEn, .extB, .extBEn, .pinAIn(portAPinIn), .pinBIn(portBPinIn));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Inputs move 1 ns after the edge, outputs are read at the same point
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic t_reset();
      repeat (12) tick();
      chk8(portAPinOe_b, OE_B_RST);
      chk8(portBPinOe_b, OE_B_RST);
      chk8(portAPinOut, OUT_RST);
      chk8(portBPullup, PULL_RST);
      chk8(altFunctionInput, 8'h00);
      rst_b = 1'b1;
      tick();
      $display("t_reset done");
   endtask

   task automatic t_mem_write();
      extMemEnable = 1'b1;
      globalPullupDisable = 1'b1;
      portAOutLatch = 8'hF0;
      portADirection = 8'hFF;
      addressPhaseActive = 1'b1;
      extAddrLow = 8'hA5;
      extDataOut = 8'h3C;
      tick();
      chk8(portAPinOe_b, 8'h00);
      chk8(portAPinOut, 8'hA5);
      chk8(portAPullup, 8'h00);
      addressPhaseActive = 1'b0;
      writePhase = 1'b1;
      tick();
      chk8(portAPinOut, 8'h3C);
      chk8(portAPinOe_b, 8'h00);
      writePhase = 1'b0;
      tick();
      chk8(portAPinOe_b, 8'hFF);
      chk8(portAPullup, 8'hF0);
      globalPullupDisable = 1'b0;
      tick();
      chk8(portAPullup, 8'h00);
      $display("t_mem_write done");
   endtask

   task automatic t_mem_read();
      extA = 8'h96;
      extAEn = 8'hFF;
      tick();
      chk8(altFunctionInput, 8'h96);
      extA = 8'h69;
      tick();
      chk8(altFunctionInput, 8'h69);
      chk8(portAPinRead, 8'h96);
      extAEn = 8'h00;
      $display("t_mem_read done");
   endtask

   task automatic t_gpio_a();
      extMemEnable = 1'b0;
      addressPhaseActive = 1'b1;
      extAddrLow = 8'hFF;
      portADirection = 8'h0F;
      portAOutLatch = 8'h55;
      tick();
      chk8(portAPinOe_b, 8'hF0);
      chk8(portAPinOut, 8'h55);
      chk8(portAPullup, 8'h50);
      addressPhaseActive = 1'b0;
      $display("t_gpio_a done");
   endtask

   task automatic t_timers();
      // Columns: t2 en, t2 val, t1C en, t1C val, legacy, latch bit 7, expected pin
      bit7Tbl = '{7'b1100001, 7'b1000010, 7'b0011001, 7'b0011100,
                  7'b1011011, 7'b1110000, 7'b0000011};
      portBDirection = 8'hF0;
      // Latch bit 5 set so a missing timer 1 A override shows on the pin
      portBOutLatch = 8'h20;
      {timer0CompareEn, timer0CompareOut, timer1CompareEnA, timer1CompareOutA} = 4'hE;
      {timer1CompareEnB, timer1CompareOutB} = 2'h3;
      for (int i = 0; i < 7; i++) begin
         {timer2CompareEn, timer2CompareOut, timer1CompareEnC, timer1CompareOutC,
          legacyCompatMode, portBOutLatch[7]} = bit7Tbl[i][6:1];
         tick();
         chk1(portBPinOut[7], bit7Tbl[i][0]);
      end
      chk8({1'b0, portBPinOut[6:4], portBPinOe_b[7:4]}, 8'h50);
      $display("t_timers done");
   endtask

   task automatic t_spi();
      {spiEnable, spiMaster, spiMasterOut, spiSckOut, spiSlaveOut} = 5'h1C;
      portBDirection = 8'h0F;
      portBOutLatch = 8'h0F;
      extB = 8'h08;
      extBEn = 8'h08;
      tick();
      chk8({4'h0, portBPinOe_b[3:0]}, 8'h08);
      chk8({6'h00, portBPinOut[2:1]}, 8'h02);
      chk1(portBPullup[3], 1'b1);
      chk1(spiMisoIn, 1'b1);
      {spiMaster, spiSlaveOut} = 2'h1;
      extB = 8'h05;
      extBEn = 8'h07;
      tick();
      chk8({4'h0, portBPinOe_b[3:0]}, 8'h07);
      chk1(portBPinOut[3], 1'b1);
      chk8({5'h00, portBPullup[2:0]}, 8'h07);
      tick();
      chk8({5'h00, spiMosiIn, spiSckIn, spiSlaveSelectIn}, 8'h05);
      chk8({4'h0, portBPinRead[3:0]}, 8'h0D);
      $display("t_spi done");
   endtask

   initial begin
      #50us;
      num_errors++;
      end_of_test();
   end

   initial begin
      rst_b = 1'b0;
      {extMemEnable, addressPhaseActive, writePhase, globalPullupDisable} = 4'h0;
      {legacyCompatMode, spiEnable, spiMaster, spiSlaveOut, spiMasterOut, spiSckOut} = 6'h00;
      {timer2CompareEn, timer2CompareOut, timer1CompareEnC, timer1CompareOutC} = 4'h0;
      {timer1CompareEnB, timer1CompareOutB, timer1CompareEnA, timer1CompareOutA} = 4'h0;
      {timer0CompareEn, timer0CompareOut} = 2'h0;
      {extAddrLow, extDataOut, portAOutLatch, portADirection} = 32'h0000_0000;
      {portBOutLatch, portBDirection, extA, extAEn, extB, extBEn} = 48'h0000_0000_0000;
      t_reset();
      t_mem_write();
      t_mem_read();
      t_gpio_a();
      t_timers();
      t_spi();
      end_of_test();
   end
endmodule
